// ===== logic/mvwd_core.sv
// Purpose: vlan tag detection, frame length check and wake-up detection
// Assumes: rx stream is one byte per cycle with valid, last and crc-good marks
// Notes: all state lives in one struct, registered by a single always_ff
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps

// Notes on behaviour
// - compare first tag identifier with frame bytes 13 and 14; flag match.
// - compare second tag identifier with frame bytes 13 and 14; flag match.
// - vlan frames may be 1522 bytes long instead of 1518.
// - reset, hard or soft, points filter loading back at dword 0.
// - after eight dwords the filter pointer wraps to the first entry.
// - filter load port is write-only; reads return zero.
// - with unicast wake enabled, wake on a frame whose address bit 0 is zero.
// - a valid wake-up frame sets the wake-frame-received flag, bit 6.
// - a valid magic packet sets the magic-packet-received flag, bit 5.
// - wake-frame enable gates all wake-up frame detection.
// - magic-packet enable turns magic packet detection on.
module mvwd_core (
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic soft_reset_i,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_data_i,
    input wire logic rx_last_i,
    input wire logic rx_good_i,
    input wire logic power_save_i,
    output logic frame_vlan_a_o,
    output logic frame_vlan_b_o,
    output logic frame_len_err_o,
    output logic wake_o,
    output logic irq_o
);
    mvwd_pkg::mvwd_state_t s;
    mvwd_pkg::mvwd_state_t next_s;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                          input logic [31:0] mask);
        merge = (old & ~mask) | (val & mask);
    endfunction

    always_comb begin
        logic [31:0] wmask;
        logic [31:0] wval;
        logic [31:0] w1c;
        logic [10:0] bi;
        logic [7:0] b;
        logic len_bad;
        logic good;
        logic wf_hit;
        logic wake;
        logic do_wfr;
        logic do_mpr;
        logic [mvwd_pkg::IST_W-1:0] ev;
        wmask = '0;
        wval = '0;
        w1c = '0;
        bi = s.byte_cnt;
        b = rx_data_i;
        len_bad = 1'b0;
        good = 1'b0;
        wf_hit = 1'b0;
        wake = 1'b0;
        do_wfr = 1'b0;
        do_mpr = 1'b0;
        ev = '0;
        next_s = s;
        next_s.vlan_a_p = 1'b0;
        next_s.vlan_b_p = 1'b0;
        next_s.len_err_p = 1'b0;
        next_s.wake_p = 1'b0;

        // ----------------------------------------
        // receive path
        // ----------------------------------------
        if (rx_valid_i) begin
            if (bi == '0) begin
                next_s.da_grp = b[0];
            end
            if (bi == mvwd_pkg::TAG_HI_IDX) begin
                next_s.tag_hi = b;
            end
            if (bi == mvwd_pkg::TAG_LO_IDX) begin
                next_s.vlan_a_hit = ({s.tag_hi, b} == s.tag_a);
                next_s.vlan_b_hit = ({s.tag_hi, b} == s.tag_b);
            end
            // filter k: dword k masks bytes 0..31, dword k+4 low byte holds their xor
            if (bi < mvwd_pkg::WF_SPAN) begin
                for (int k = 0; k < mvwd_pkg::WF_FILTERS; k++) begin
                    if (s.filt[k][bi[4:0]]) begin
                        next_s.csum[k] = s.csum[k] ^ b;
                    end
                end
            end
            if (s.magic_packet_enable) begin
                case (s.mg_state)
                    mvwd_pkg::MG_SYNC: begin
                        if (b == mvwd_pkg::MAGIC_FF) begin
                            if (s.ff_cnt != mvwd_pkg::FF_RUN) begin
                                next_s.ff_cnt = s.ff_cnt + 3'h1;
                            end
                        end else if (s.ff_cnt == mvwd_pkg::FF_RUN && b == s.sta[7:0]) begin
                            next_s.mg_state = mvwd_pkg::MG_ADDR;
                            next_s.mac_idx = 3'h1;
                            next_s.mac_rep = '0;
                        end else begin
                            next_s.ff_cnt = '0;
                        end
                    end
                    mvwd_pkg::MG_ADDR: begin
                        if (b == s.sta[{s.mac_idx, 3'h0} +: 8]) begin
                            if (s.mac_idx == mvwd_pkg::MAC_LAST) begin
                                next_s.mac_idx = '0;
                                next_s.mac_rep = s.mac_rep + 5'h1;
                                if (s.mac_rep == mvwd_pkg::MAC_REPS_LAST) begin
                                    next_s.magic_hit = 1'b1;
                                    next_s.mg_state = mvwd_pkg::MG_SYNC;
                                    next_s.ff_cnt = '0;
                                end
                            end else begin
                                next_s.mac_idx = s.mac_idx + 3'h1;
                            end
                        end else begin
                            // a broken copy may itself start a new sync run
                            next_s.mg_state = mvwd_pkg::MG_SYNC;
                            next_s.ff_cnt = (b == mvwd_pkg::MAGIC_FF) ? 3'h1 : 3'h0;
                        end
                    end
                    default: begin
                        next_s.mg_state = mvwd_pkg::MG_SYNC;
                    end
                endcase
            end
            if (s.byte_cnt != mvwd_pkg::CNT_SAT) begin
                next_s.byte_cnt = s.byte_cnt + 11'h1;
            end
            if (rx_last_i) begin
                // frame length is bi+1, so length > max equals bi >= max
                if (next_s.vlan_a_hit || next_s.vlan_b_hit) begin
                    len_bad = (bi >= mvwd_pkg::LEN_MAX_VLAN);
                end else begin
                    len_bad = (bi >= mvwd_pkg::LEN_MAX);
                end
                good = rx_good_i && !len_bad;
                for (int k = 0; k < mvwd_pkg::WF_FILTERS; k++) begin
                    if (|s.filt[k] &&
                        next_s.csum[k] == s.filt[k + mvwd_pkg::WF_FILTERS][7:0]) begin
                        wf_hit = 1'b1;
                    end
                end
                do_wfr = good && s.wfen && wf_hit;
                do_mpr = good && s.magic_packet_enable && next_s.magic_hit;
                wake = power_save_i && good &&
                       (do_wfr || do_mpr || (s.guen && !next_s.da_grp));
                next_s.vlan_a_p = next_s.vlan_a_hit;
                next_s.vlan_b_p = next_s.vlan_b_hit;
                next_s.len_err_p = len_bad;
                next_s.wake_p = wake;
                ev = {wake, do_wfr, do_mpr, len_bad, next_s.vlan_b_hit, next_s.vlan_a_hit};
                next_s.byte_cnt = '0;
                next_s.vlan_a_hit = 1'b0;
                next_s.vlan_b_hit = 1'b0;
                next_s.csum = '0;
                next_s.mg_state = mvwd_pkg::MG_SYNC;
                next_s.ff_cnt = '0;
                next_s.magic_hit = 1'b0;
            end
        end

        // ----------------------------------------
        // axi4-lite write
        // ----------------------------------------
        if (s.awready && s_axi_awvalid) begin
            next_s.aw_ok = 1'b1;
            next_s.awaddr = s_axi_awaddr;
        end
        if (s.wready && s_axi_wvalid) begin
            next_s.w_ok = 1'b1;
            next_s.wdata = s_axi_wdata;
            next_s.wstrb = s_axi_wstrb;
        end
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end
        if (s.aw_ok && s.w_ok && !s.bvalid) begin
            for (int i = 0; i < 4; i++) begin
                wmask[i*8 +: 8] = {8{s.wstrb[i]}};
            end
            w1c = s.wdata & wmask;
            next_s.aw_ok = 1'b0;
            next_s.w_ok = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = mvwd_pkg::RESP_OKAY;
            case (s.awaddr[mvwd_pkg::AW-1:mvwd_pkg::ADDR_LSB])
                mvwd_pkg::IDX_TAG_A: begin
                    wval = merge({16'h0, s.tag_a}, s.wdata, wmask);
                    next_s.tag_a = wval[mvwd_pkg::TAG_W-1:0];
                end
                mvwd_pkg::IDX_TAG_B: begin
                    wval = merge({16'h0, s.tag_b}, s.wdata, wmask);
                    next_s.tag_b = wval[mvwd_pkg::TAG_W-1:0];
                end
                mvwd_pkg::IDX_FILT: begin
                    next_s.filt[s.fptr] = merge(s.filt[s.fptr], s.wdata, wmask);
                    next_s.fptr = s.fptr + 3'h1;
                end
                mvwd_pkg::IDX_WCSR: begin
                    wval = merge({22'h0, s.guen, 6'h0, s.wfen, s.magic_packet_enable, 1'b0}, s.wdata, wmask);
                    next_s.guen = wval[mvwd_pkg::WC_GUE];
                    next_s.wfen = wval[mvwd_pkg::WC_WFEN];
                    next_s.magic_packet_enable = wval[mvwd_pkg::WC_MAGIC_PACKET_ENABLE];
                    if (w1c[mvwd_pkg::WC_WFR]) begin
                        next_s.wfr = 1'b0;
                    end
                    if (w1c[mvwd_pkg::WC_MPR]) begin
                        next_s.magic_packet_received = 1'b0;
                    end
                end
                mvwd_pkg::IDX_IST: begin
                    next_s.ist = s.ist & ~w1c[mvwd_pkg::IST_W-1:0];
                end
                mvwd_pkg::IDX_IMASK: begin
                    wval = merge({26'h0, s.imask}, s.wdata, wmask);
                    next_s.imask = wval[mvwd_pkg::IST_W-1:0];
                end
                mvwd_pkg::IDX_STA_LO: begin
                    next_s.sta[31:0] = merge(s.sta[31:0], s.wdata, wmask);
                end
                mvwd_pkg::IDX_STA_HI: begin
                    wval = merge({16'h0, s.sta[47:32]}, s.wdata, wmask);
                    next_s.sta[47:32] = wval[mvwd_pkg::STA_HI_W-1:0];
                end
                default: begin
                    next_s.bresp = mvwd_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (soft_reset_i) begin
            next_s.fptr = '0;
        end
        // hardware set beats a same-cycle software clear
        next_s.ist = next_s.ist | ev;
        next_s.wfr = next_s.wfr | do_wfr;
        next_s.magic_packet_received = next_s.magic_packet_received | do_mpr;

        // ----------------------------------------
        // axi4-lite read
        // ----------------------------------------
        if (s.arready && s_axi_arvalid) begin
            next_s.rvalid = 1'b1;
            next_s.rresp = mvwd_pkg::RESP_OKAY;
            next_s.rdata = '0;
            case (s_axi_araddr[mvwd_pkg::AW-1:mvwd_pkg::ADDR_LSB])
                mvwd_pkg::IDX_TAG_A: next_s.rdata = {16'h0, s.tag_a};
                mvwd_pkg::IDX_TAG_B: next_s.rdata = {16'h0, s.tag_b};
                mvwd_pkg::IDX_FILT: next_s.rdata = '0;
                mvwd_pkg::IDX_WCSR: begin
                    next_s.rdata[mvwd_pkg::WC_GUE] = s.guen;
                    next_s.rdata[mvwd_pkg::WC_WFR] = s.wfr;
                    next_s.rdata[mvwd_pkg::WC_MPR] = s.magic_packet_received;
                    next_s.rdata[mvwd_pkg::WC_WFEN] = s.wfen;
                    next_s.rdata[mvwd_pkg::WC_MAGIC_PACKET_ENABLE] = s.magic_packet_enable;
                end
                mvwd_pkg::IDX_IST: next_s.rdata = {26'h0, s.ist};
                mvwd_pkg::IDX_IMASK: next_s.rdata = {26'h0, s.imask};
                mvwd_pkg::IDX_STA_LO: next_s.rdata = s.sta[31:0];
                mvwd_pkg::IDX_STA_HI: next_s.rdata = {16'h0, s.sta[47:32]};
                default: next_s.rresp = mvwd_pkg::RESP_SLVERR;
            endcase
        end else if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end
        // one write and one read in flight; ready reopens after the answer
        next_s.awready = !next_s.aw_ok && !next_s.bvalid;
        next_s.wready = !next_s.w_ok && !next_s.bvalid;
        next_s.arready = !next_s.rvalid;
        next_s.irq = |(next_s.ist & next_s.imask);
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign s_axi_awready = s.awready;
    assign s_axi_wready = s.wready;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_arready = s.arready;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;
    assign frame_vlan_a_o = s.vlan_a_p;
    assign frame_vlan_b_o = s.vlan_b_p;
    assign frame_len_err_o = s.len_err_p;
    assign wake_o = s.wake_p;
    assign irq_o = s.irq;
endmodule

// ===== logic/mvwd_pkg.sv
// Purpose: constants and state types for the vlan tag and wake-up detect block
// Assumes: axi4-lite register slave, byte-wide receive stream
// Notes: register index times four gives the byte address
package mvwd_pkg;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam int AW = 8;
    localparam int ADDR_LSB = 2;
    localparam logic [5:0] IDX_TAG_A = 6'h09;
    localparam logic [5:0] IDX_TAG_B = 6'h0a;
    localparam logic [5:0] IDX_FILT = 6'h0b;
    localparam logic [5:0] IDX_WCSR = 6'h0c;
    localparam logic [5:0] IDX_IST = 6'h10;
    localparam logic [5:0] IDX_IMASK = 6'h11;
    localparam logic [5:0] IDX_STA_LO = 6'h12;
    localparam logic [5:0] IDX_STA_HI = 6'h13;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int WC_GUE = 9;
    localparam int WC_WFR = 6;
    localparam int WC_MPR = 5;
    localparam int WC_WFEN = 2;
    localparam int WC_MAGIC_PACKET_ENABLE = 1;
    localparam int IST_W = 6;
    localparam int TAG_W = 16;
    localparam int STA_HI_W = 16;
    // ----------------------------------------
    // frame figures
    // ----------------------------------------
    localparam logic [10:0] TAG_HI_IDX = 11'h00c;
    localparam logic [10:0] TAG_LO_IDX = 11'h00d;
    localparam logic [10:0] LEN_MAX = 11'h5ee;
    localparam logic [10:0] LEN_MAX_VLAN = 11'h5f2;
    localparam logic [10:0] CNT_SAT = 11'h7ff;
    localparam logic [10:0] WF_SPAN = 11'h020;
    localparam int FILT_WORDS = 8;
    localparam int WF_FILTERS = 4;
    localparam logic [7:0] MAGIC_FF = 8'hff;
    localparam logic [2:0] FF_RUN = 3'h6;
    localparam logic [2:0] MAC_LAST = 3'h5;
    localparam logic [4:0] MAC_REPS_LAST = 5'hf;

    typedef enum logic {MG_SYNC, MG_ADDR} mvwd_magic_t;

    typedef struct packed {
        logic aw_ok;
        logic w_ok;
        logic [AW-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [TAG_W-1:0] tag_a;
        logic [TAG_W-1:0] tag_b;
        logic [FILT_WORDS-1:0][31:0] filt;
        logic [2:0] fptr;
        logic guen;
        logic wfen;
        logic magic_packet_enable;
        logic wfr;
        logic magic_packet_received;
        logic [IST_W-1:0] ist;
        logic [IST_W-1:0] imask;
        logic [47:0] sta;
        logic irq;
        logic [10:0] byte_cnt;
        logic [7:0] tag_hi;
        logic vlan_a_hit;
        logic vlan_b_hit;
        logic da_grp;
        logic [WF_FILTERS-1:0][7:0] csum;
        mvwd_magic_t mg_state;
        logic [2:0] ff_cnt;
        logic [2:0] mac_idx;
        logic [4:0] mac_rep;
        logic magic_hit;
        logic vlan_a_p;
        logic vlan_b_p;
        logic len_err_p;
        logic wake_p;
    } mvwd_state_t;
endpackage

// ===== verif/mvwd_core_chk.sv
// Purpose: port-level checker for the vlan tag and wake-up detect block
// Assumes: single clock domain, reset asynchronous and active low
// Notes: frame length is recounted here from the rx strobes
`timescale 1ns/1ps
module mvwd_core_chk (
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic rx_valid_i,
    input wire logic rx_last_i,
    input wire logic power_save_i,
    input wire logic frame_vlan_a_o,
    input wire logic frame_vlan_b_o,
    input wire logic frame_len_err_o,
    input wire logic wake_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!arst_n_i);
    // bytes seen so far in the current frame
    logic [11:0] cnt;
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt <= 12'h000;
        end else if (rx_valid_i) begin
            cnt <= rx_last_i ? 12'h000 : cnt + 12'h001;
        end
    end
    aw_drop_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("awready stayed high after address taken");
    b_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write channels ready while response pending");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write response dropped before bready");
    r_exact_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data not one cycle after address");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data unstable");
    ar_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("arready high while read pending");
    flag_cause_a: assert property ((frame_vlan_a_o || frame_vlan_b_o)
        |-> $past(rx_valid_i && rx_last_i)) else $error("tag flag without frame end");
    len_ok_a: assert property (rx_valid_i && rx_last_i && cnt <= 12'h5ed
        |=> !frame_len_err_o) else $error("length error on legal frame");
    len_over_a: assert property (rx_valid_i && rx_last_i && cnt >= 12'h5f2
        |=> frame_len_err_o) else $error("overlong frame not flagged");
    wake_cause_a: assert property (wake_o
        |-> $past(rx_valid_i && rx_last_i && power_save_i)) else $error("stray wake pulse");
endmodule
bind mvwd_core mvwd_core_chk u_chk (.*);

// ===== verif/mvwd_core_test.sv
// Purpose: self-checking bench for the vlan tag and wake-up detect block
// Assumes: register byte address is index times four
// Notes: frame checks only see whether each pulse count moved, so missing or stray pulses show
`timescale 1ns/1ps
module mvwd_core_test;
    typedef struct packed {
        logic [7:0] a;
        logic [31:0] d;
        logic [31:0] q;
        logic [1:0] r;
    } mvwd_row_t;
    localparam logic [1:0] OKR = mvwd_pkg::RESP_OKAY;
    localparam logic [1:0] ERR = mvwd_pkg::RESP_SLVERR;
    logic clk, rst_n, soft_rst, psave, irq, rxv, rxl, rxg, fa, fb, fe, wk;
    logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr, araddr, rxd;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    int cnt [4];
    int fail_count, tests_run, i, lag;
    mvwd_row_t rows [0:7] = '{
        '{8'h24, 32'hffff8100, 32'h00008100, OKR},
        '{8'h28, 32'habcd8100, 32'h00008100, OKR},
        '{8'h2c, 32'h12345678, 32'h00000000, OKR},
        '{8'h30, 32'hffffffff, 32'h00000206, OKR},
        '{8'h44, 32'h0000003f, 32'h0000003f, OKR},
        '{8'h48, 32'h33221100, 32'h33221100, OKR},
        '{8'h4c, 32'hffff5544, 32'h00005544, OKR},
        '{8'hf0, 32'ha5a5a5a5, 32'h00000000, ERR}
    };
    mvwd_core dut (
        .ref_clk_i(clk), .arst_n_i(rst_n), .soft_reset_i(soft_rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rx_valid_i(rxv),
        .rx_data_i(rxd), .rx_last_i(rxl), .rx_good_i(rxg), .power_save_i(psave),
        .frame_vlan_a_o(fa), .frame_vlan_b_o(fb), .frame_len_err_o(fe),
        .wake_o(wk), .irq_o(irq)
    );
    mvwd_rx_model rx (.clk_i(clk), .valid_o(rxv), .data_o(rxd), .last_o(rxl), .good_o(rxg));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cnt[0] <= cnt[0] + int'(fa);
        cnt[1] <= cnt[1] + int'(fb);
        cnt[2] <= cnt[2] + int'(fe);
        cnt[3] <= cnt[3] + int'(wk);
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // lag holds bready or rready low for that many edges, so the slave must hold its answer
    task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        logic done;
        n = 0;
        done = 1'b0;
        @(posedge clk);
        {awaddr, wdata} <= {a, d};
        {awvalid, wvalid} <= 2'h3;
        do begin
            @(posedge clk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            done = bvalid === 1'b1 && bready === 1'b1;
            if (!done && n >= lag && n < 200) bready <= 1'b1;
        end while (!done && n < 200);
        bready <= 1'b0;
        chk(32'(done), 32'h1);
        chk(32'(bresp), 32'(er));
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        int n;
        logic done;
        n = 0;
        done = 1'b0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arready) arvalid <= 1'b0;
            done = rvalid === 1'b1 && rready === 1'b1;
            if (!done && n >= lag && n < 200) rready <= 1'b1;
        end while (!done && n < 200);
        rready <= 1'b0;
        chk(32'(done), 32'h1);
        chk(rdata, exp);
        chk(32'(rresp), 32'(er));
    endtask
    // ex bits: wake, length error, second tag, first tag
    task automatic xf(input int len, input logic [7:0] b0, input logic [15:0] tag,
            input logic mg, input int gap, input logic [3:0] ex);
        int b [4];
        int k;
        logic [3:0] got;
        b = cnt;
        for (k = 0; k < len; k++) rx.mem[k] = 8'h3c;
        rx.mem[0] = b0;
        {rx.mem[12], rx.mem[13]} = tag;
        for (k = 0; k < 102 && mg; k++) rx.mem[14 + k] = k < 6 ? 8'hff : 8'((k % 6) * 8'h11);
        rx.send(len, gap);
        repeat (3) @(posedge clk);
        for (k = 0; k < 4; k++) got[k] = cnt[k] != b[k];
        chk(32'(got), 32'(ex));
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        #1000000;
        fail_count++;
        wrap_up();
    end
    initial begin
        {rst_n, soft_rst, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hf;
        psave = 1'b1;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        for (i = 0; i < 8; i++) begin
            wrc(rows[i].a, rows[i].d, rows[i].r);
            rdc(rows[i].a, rows[i].q, rows[i].r);
        end
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        for (i = 0; i < 5; i++) rdc(rows[i].a, 32'h0, OKR);
        for (i = 0; i < 7; i++) wrc(rows[i].a, rows[i].d, OKR);
        wrc(8'h28, 32'h000088a8, OKR);
        wrc(8'h30, 32'h0, OKR);
        xf(1522, 8'h01, 16'h8100, 1'b0, 0, 4'h1);
        xf(1519, 8'h01, 16'h88a8, 1'b0, 1, 4'h2);
        xf(1519, 8'h01, 16'h0800, 1'b0, 0, 4'h4);
        xf(1523, 8'h01, 16'h8100, 1'b0, 0, 4'h5);
        xf(1518, 8'h01, 16'h0800, 1'b0, 0, 4'h0);
        chk(32'(irq), 32'h1);
        rdc(8'h40, 32'h7, OKR);
        wrc(8'h40, 32'h3f, OKR);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h0);
        lag = 4;
        wrc(8'h44, 32'h0, OKR);
        xf(64, 8'h01, 16'h88a8, 1'b0, 0, 4'h2);
        chk(32'(irq), 32'h0);
        rdc(8'h40, 32'h2, OKR);
        lag = 0;
        wrc(8'h30, 32'h200, OKR);
        xf(64, 8'h00, 16'h0800, 1'b0, 0, 4'h8);
        xf(64, 8'h01, 16'h0800, 1'b0, 0, 4'h0);
        psave <= 1'b0;
        xf(64, 8'h00, 16'h0800, 1'b0, 0, 4'h0);
        psave <= 1'b1;
        rx.crc_bad <= 1'b1;
        xf(64, 8'h00, 16'h0800, 1'b0, 0, 4'h0);
        rx.crc_bad <= 1'b0;
        wrc(8'h30, 32'h2, OKR);
        xf(128, 8'h01, 16'h0800, 1'b1, 0, 4'h8);
        rdc(8'h30, 32'h22, OKR);
        wrc(8'h30, 32'h20, OKR);
        xf(128, 8'h01, 16'h0800, 1'b1, 0, 4'h0);
        rdc(8'h30, 32'h0, OKR);
        soft_rst <= 1'b1;
        @(posedge clk);
        soft_rst <= 1'b0;
        for (i = 0; i < 8; i++) wrc(8'h2c, i == 0 ? 32'h1 : (i == 4 ? 32'h5b : 32'h0), OKR);
        wrc(8'h30, 32'h4, OKR);
        xf(64, 8'h5b, 16'h0800, 1'b0, 0, 4'h8);
        rdc(8'h30, 32'h44, OKR);
        wrc(8'h30, 32'h40, OKR);
        xf(64, 8'h5b, 16'h0800, 1'b0, 0, 4'h0);
        wrc(8'h30, 32'h4, OKR);
        wrc(8'h2c, 32'h0, OKR);
        xf(64, 8'h5b, 16'h0800, 1'b0, 0, 4'h0);
        soft_rst <= 1'b1;
        @(posedge clk);
        soft_rst <= 1'b0;
        wrc(8'h2c, 32'h1, OKR);
        xf(64, 8'h5b, 16'h0800, 1'b0, 0, 4'h8);
        wstrb <= 4'h1;
        wrc(8'h24, 32'h0000aa55, OKR);
        wstrb <= 4'hf;
        rdc(8'h24, 32'h00008155, OKR);
        wrap_up();
    end
endmodule

// ===== verif/mvwd_rx_model.sv
// Purpose: receive byte source standing in for the phy side
// Assumes: bench fills mem, then calls send
// Notes: idle data and crc mark churn so a stale byte never looks valid
`timescale 1ns/1ps
module mvwd_rx_model (
    input wire logic clk_i,
    output logic valid_o,
    output logic [7:0] data_o,
    output logic last_o,
    output logic good_o
);
    logic [7:0] mem [0:2047];
    logic [7:0] cur;
    logic [7:0] noise;
    // bench raises this to end the next frame with a failed crc
    logic crc_bad;
    assign data_o = valid_o ? cur : noise;
    assign good_o = last_o ? !crc_bad : noise[0];
    initial begin
        {valid_o, last_o} = '0;
        {cur, noise} = '0;
        crc_bad = 1'b0;
    end
    always @(posedge clk_i) begin
        noise <= noise + 8'h35;
    end
    // gap idles between bytes emulate a slow line
    task automatic send(input int len, input int gap);
        int i;
        for (i = 0; i < len; i++) begin
            @(posedge clk_i);
            valid_o <= 1'b1;
            cur <= mem[i];
            last_o <= (i == len - 1);
            repeat (gap) begin
                @(posedge clk_i);
                {valid_o, last_o} <= 2'h0;
            end
        end
        @(posedge clk_i);
        {valid_o, last_o} <= 2'h0;
    endtask
endmodule
